// ===== inc/ptp_regs_pkg.sv
// constants for the phy test-pattern control register bank
`default_nettype none
package ptp_regs_pkg;

    // ------------------------------------------------------------
    // register port and offsets
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 16;
    localparam logic [4:0] TENMEG_STATUS_CONTROL_OFS = 5'h1A;
    localparam logic [4:0] SELFTEST_PATTERN_EXT_OFS = 5'h1B;
    localparam logic [4:0] ENERGY_SENSE_CONTROL_OFS = 5'h1D;

    // ------------------------------------------------------------
    // tenmeg_status_control fields
    // ------------------------------------------------------------
    localparam int unsigned LONG_TX_GUARD_OFF_BIT = 0;
    localparam int unsigned SQE_TEST_INHIBIT_BIT = 1;
    localparam int unsigned POLARITY_FLAG_BIT = 4;
    localparam logic LONG_TX_GUARD_OFF_RST = 1'h0;
    localparam logic SQE_TEST_INHIBIT_RST = 1'h0;

    // ------------------------------------------------------------
    // selftest_pattern_ext fields
    // ------------------------------------------------------------
    localparam int unsigned ERR_TALLY_LSB = 8;
    localparam int unsigned ERR_TALLY_W = 8;
    localparam int unsigned RSVD_HI_LSB = 6;
    localparam int unsigned NONSTOP_TX_BIT = 5;
    localparam int unsigned LINE_PATTERN_ON_BIT = 4;
    localparam int unsigned RSVD_LO_BIT = 3;
    localparam int unsigned PATTERN_SPACING_BIT = 2;
    localparam int unsigned PATTERN_CHOICE_LSB = 0;
    localparam logic [7:0] SELFTEST_CTRL_RST = 8'h00;

    // ------------------------------------------------------------
    // energy_sense_control fields
    // ------------------------------------------------------------
    localparam int unsigned ENERGY_SENSE_ON_BIT = 15;
    localparam logic ENERGY_SENSE_ON_RST = 1'h0;

    // ------------------------------------------------------------
    // pattern choices
    // ------------------------------------------------------------
    localparam logic [1:0] PAT_DATA_EOP_A = 2'h0;
    localparam logic [1:0] PAT_DATA_EOP_B = 2'h1;
    localparam logic [1:0] PAT_LINK_PULSES = 2'h2;
    localparam logic [1:0] PAT_TONE_ONES = 2'h3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 50;
    localparam int unsigned GAP_LONG_US = 15;
    localparam int unsigned GAP_SHORT_US = 10;
    localparam int unsigned GAP_W = 10;
    localparam logic [9:0] GAP_LONG_CYC = 10'(GAP_LONG_US * CLK_MHZ);
    localparam logic [9:0] GAP_SHORT_CYC = 10'(GAP_SHORT_US * CLK_MHZ);

endpackage
`default_nettype wire

// ===== rtl/ptp_sat_counter.sv
// saturating event counter with synchronous restart
`timescale 1ns/1ps
`default_nettype none
module ptp_sat_counter #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic restart_in,
    input wire logic event_in,
    output logic [WIDTH-1:0] count_out
);

    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;

    // ------------------------------------------------------------
    // next count
    // ------------------------------------------------------------
    always_comb begin
        count_nxt = count_r;
        if (restart_in) begin
            count_nxt = '0;
        end else if (event_in && (count_r != '1)) begin
            count_nxt = count_r + WIDTH'(1);
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign count_out = count_r;

endmodule
`default_nettype wire

// ===== rtl/ptp_ctrl_regs.sv
// control and status registers for 10 Mb, self-test and energy-sense
// controls of a 10/100 ethernet transceiver
`timescale 1ns/1ps
`default_nettype none
module ptp_ctrl_regs (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [ptp_regs_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [ptp_regs_pkg::DATA_W-1:0] reg_wdata_in,
    output logic [ptp_regs_pkg::DATA_W-1:0] reg_rdata_out,
    output logic reg_rvalid_out,
    input wire logic speed_100_in,
    input wire logic full_duplex_in,
    input wire logic polarity_inv_in,
    input wire logic selftest_start_in,
    input wire logic selftest_active_in,
    input wire logic nibble_err_in,
    output logic heartbeat_en_out,
    output logic jabber_en_out,
    output logic polarity_copy_out,
    output logic selftest_nonstop_tx_out,
    output logic line_pattern_on_out,
    output logic [1:0] pattern_choice_out,
    output logic tone_mode_out,
    output logic [ptp_regs_pkg::GAP_W-1:0] pattern_gap_cycles_out,
    output logic energy_sense_on_out
);
    import ptp_regs_pkg::*;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic sqe_test_inhibit_r;
    logic sqe_test_inhibit_nxt;
    logic long_tx_guard_off_r;
    logic long_tx_guard_off_nxt;
    logic polarity_flag_r;
    logic polarity_flag_nxt;
    logic [7:0] selftest_ctrl_r;
    logic [7:0] selftest_ctrl_nxt;
    logic energy_sense_on_r;
    logic energy_sense_on_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    logic heartbeat_en_r;
    logic heartbeat_en_nxt;
    logic jabber_en_r;
    logic jabber_en_nxt;
    logic tone_mode_r;
    logic tone_mode_nxt;
    logic [GAP_W-1:0] gap_cycles_r;
    logic [GAP_W-1:0] gap_cycles_nxt;
    logic [ERR_TALLY_W-1:0] err_tally;
    logic wr_tenmeg;
    logic wr_selftest;
    logic wr_energy;
    logic rd_tenmeg;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
        hit = (addr == ofs);
    endfunction

    assign wr_tenmeg = reg_wr_in && hit(reg_addr_in, TENMEG_STATUS_CONTROL_OFS);
    assign wr_selftest = reg_wr_in && hit(reg_addr_in, SELFTEST_PATTERN_EXT_OFS);
    assign wr_energy = reg_wr_in && hit(reg_addr_in, ENERGY_SENSE_CONTROL_OFS);
    assign rd_tenmeg = reg_rd_in && hit(reg_addr_in, TENMEG_STATUS_CONTROL_OFS);

    // ------------------------------------------------------------
    // error tally
    // ------------------------------------------------------------
    // count errored nibbles
    ptp_sat_counter #(
        .WIDTH(ERR_TALLY_W)
    ) u_err_tally (
        .sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in),
        .restart_in(selftest_start_in),
        .event_in(nibble_err_in && selftest_active_in),
        .count_out(err_tally)
    );

    // ------------------------------------------------------------
    // writable fields
    // ------------------------------------------------------------
    always_comb begin
        sqe_test_inhibit_nxt = sqe_test_inhibit_r;
        long_tx_guard_off_nxt = long_tx_guard_off_r;
        selftest_ctrl_nxt = selftest_ctrl_r;
        energy_sense_on_nxt = energy_sense_on_r;
        if (wr_tenmeg) begin
            sqe_test_inhibit_nxt = reg_wdata_in[SQE_TEST_INHIBIT_BIT];
            long_tx_guard_off_nxt = reg_wdata_in[LONG_TX_GUARD_OFF_BIT];
        end
        // reserved bits are stored as written; software keeps them zero
        if (wr_selftest) begin
            selftest_ctrl_nxt = reg_wdata_in[7:0];
        end
        if (wr_energy) begin
            energy_sense_on_nxt = reg_wdata_in[ENERGY_SENSE_ON_BIT];
        end
    end

    // ------------------------------------------------------------
    // polarity flag
    // ------------------------------------------------------------
    always_comb begin
        polarity_flag_nxt = polarity_inv_in | (polarity_flag_r & ~rd_tenmeg);
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb begin
        rdata_nxt = rdata_r;
        rvalid_nxt = reg_rd_in;
        if (reg_rd_in) begin
            rdata_nxt = '0;
            unique case (reg_addr_in)
                TENMEG_STATUS_CONTROL_OFS: begin
                    rdata_nxt[SQE_TEST_INHIBIT_BIT] = sqe_test_inhibit_r;
                    rdata_nxt[LONG_TX_GUARD_OFF_BIT] = long_tx_guard_off_r;
                    rdata_nxt[POLARITY_FLAG_BIT] = polarity_flag_r;
                end
                SELFTEST_PATTERN_EXT_OFS: begin
                    rdata_nxt[ERR_TALLY_LSB +: ERR_TALLY_W] = err_tally;
                    rdata_nxt[7:0] = selftest_ctrl_r;
                end
                ENERGY_SENSE_CONTROL_OFS: begin
                    rdata_nxt[ENERGY_SENSE_ON_BIT] = energy_sense_on_r;
                end
                default: begin
                    rdata_nxt = '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // derived controls
    // ------------------------------------------------------------
    always_comb begin
        // inhibit in 10 Mb half duplex
        // heartbeat forced off at 100 Mb or full duplex; jabber forced off at 100 Mb only
        heartbeat_en_nxt = !sqe_test_inhibit_r && !speed_100_in && !full_duplex_in;
        jabber_en_nxt = !long_tx_guard_off_r && !speed_100_in;
        tone_mode_nxt = selftest_ctrl_r[LINE_PATTERN_ON_BIT]
            && (selftest_ctrl_r[PATTERN_CHOICE_LSB +: 2] == PAT_TONE_ONES);
        gap_cycles_nxt = selftest_ctrl_r[PATTERN_SPACING_BIT] ? GAP_LONG_CYC : GAP_SHORT_CYC;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // zero defaults at reset, except gap_cycles_r, which loads GAP_SHORT_CYC
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sqe_test_inhibit_r <= SQE_TEST_INHIBIT_RST;
            long_tx_guard_off_r <= LONG_TX_GUARD_OFF_RST;
            polarity_flag_r <= 1'h0;
            selftest_ctrl_r <= SELFTEST_CTRL_RST;
            energy_sense_on_r <= ENERGY_SENSE_ON_RST;
            rdata_r <= 16'h0000;
            rvalid_r <= 1'h0;
            heartbeat_en_r <= 1'h0;
            jabber_en_r <= 1'h0;
            tone_mode_r <= 1'h0;
            gap_cycles_r <= GAP_SHORT_CYC;
        end else begin
            sqe_test_inhibit_r <= sqe_test_inhibit_nxt;
            long_tx_guard_off_r <= long_tx_guard_off_nxt;
            polarity_flag_r <= polarity_flag_nxt;
            selftest_ctrl_r <= selftest_ctrl_nxt;
            energy_sense_on_r <= energy_sense_on_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            heartbeat_en_r <= heartbeat_en_nxt;
            jabber_en_r <= jabber_en_nxt;
            tone_mode_r <= tone_mode_nxt;
            gap_cycles_r <= gap_cycles_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata_out = rdata_r;
    assign reg_rvalid_out = rvalid_r;
    assign heartbeat_en_out = heartbeat_en_r;
    assign jabber_en_out = jabber_en_r;
    assign polarity_copy_out = polarity_flag_r;
    assign selftest_nonstop_tx_out = selftest_ctrl_r[NONSTOP_TX_BIT];
    assign line_pattern_on_out = selftest_ctrl_r[LINE_PATTERN_ON_BIT];
    assign pattern_choice_out = selftest_ctrl_r[PATTERN_CHOICE_LSB +: 2];
    assign tone_mode_out = tone_mode_r;
    assign pattern_gap_cycles_out = gap_cycles_r;
    assign energy_sense_on_out = energy_sense_on_r;

endmodule
`default_nettype wire

// ===== testbench/ptp_mgmt_model.sv
// management-side master model driving the register port
`timescale 1ns/1ps
`default_nettype none
module ptp_mgmt_model (
    input wire logic clk_in,
    output logic [4:0] addr_out,
    output logic wr_out,
    output logic rd_out,
    output logic [15:0] wdata_out,
    input wire logic [15:0] rdata_in,
    input wire logic rvalid_in
);
    initial begin
        {addr_out, wr_out, rd_out, wdata_out} = '0;
    end
    // reserved bits 7:6 and 3 of 0x1B always go out as zero
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk_in);
        addr_out = a;
        wdata_out = (a == 5'h1B) ? (d & 16'hFF37) : d;
        wr_out = 1'b1;
        @(negedge clk_in);
        wr_out = 1'b0;
        // released lines show the inverse so stale values cannot pass
        addr_out = ~a;
        wdata_out = ~wdata_out;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(negedge clk_in);
        addr_out = a;
        rd_out = 1'b1;
        @(negedge clk_in);
        rd_out = 1'b0;
        addr_out = ~a;
        d = rvalid_in ? rdata_in : 16'hXXXX;
    endtask
endmodule
`default_nettype wire

// ===== testbench/ptp_ctrl_regs_asserts.sv
// port-level checker for the phy test-pattern control registers
`timescale 1ns/1ps
`default_nettype none
module ptp_ctrl_regs_chk (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [ptp_regs_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [ptp_regs_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_rvalid_out,
    input wire logic speed_100_in,
    input wire logic full_duplex_in,
    input wire logic polarity_inv_in,
    input wire logic heartbeat_en_out,
    input wire logic jabber_en_out,
    input wire logic polarity_copy_out,
    input wire logic selftest_nonstop_tx_out,
    input wire logic line_pattern_on_out,
    input wire logic [1:0] pattern_choice_out,
    input wire logic tone_mode_out,
    input wire logic [ptp_regs_pkg::GAP_W-1:0] pattern_gap_cycles_out,
    input wire logic energy_sense_on_out
);
    import ptp_regs_pkg::*;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    logic w1a, w1b;
    assign w1a = reg_wr_in && reg_addr_in == TENMEG_STATUS_CONTROL_OFS;
    assign w1b = reg_wr_in && reg_addr_in == SELFTEST_PATTERN_EXT_OFS;
    AST_RVALID: assert property (reg_rd_in |=> reg_rvalid_out)
        else $error("read answer missing");
    AST_HB_FAST: assert property ((speed_100_in || full_duplex_in) |=> !heartbeat_en_out)
        else $error("heartbeat on at 100 Mb or full duplex");
    AST_HB_INHIBIT: assert property (w1a && reg_wdata_in[1] ##1 !w1a |=> !heartbeat_en_out)
        else $error("heartbeat not inhibited");
    AST_JAB_GUARD: assert property (w1a && reg_wdata_in[0] ##1 !w1a |=> !jabber_en_out)
        else $error("jabber guard still on");
    AST_FIELDS: assert property (w1b |=>
        {selftest_nonstop_tx_out, line_pattern_on_out, pattern_choice_out}
        == {$past(reg_wdata_in[5:4]), $past(reg_wdata_in[1:0])})
        else $error("self-test fields not as written");
    AST_GAP: assert property (w1b ##1 !w1b |=> pattern_gap_cycles_out ==
        ($past(reg_wdata_in[2], 2) ? GAP_LONG_CYC : GAP_SHORT_CYC))
        else $error("pattern gap wrong");
    AST_TONE: assert property (w1b ##1 !w1b |=> tone_mode_out ==
        ($past(reg_wdata_in[4], 2) && $past(reg_wdata_in[1:0], 2) == PAT_TONE_ONES))
        else $error("tone mode wrong");
    AST_ENERGY: assert property (reg_wr_in && reg_addr_in == 5'h1D
        |=> energy_sense_on_out == $past(reg_wdata_in[15]))
        else $error("energy sense bit wrong");
    AST_POL_CLR: assert property (reg_rd_in && reg_addr_in == 5'h1A && !polarity_inv_in
        |=> !polarity_copy_out)
        else $error("polarity flag not cleared by read");
    AST_POL_SET: assert property (polarity_inv_in |=> polarity_copy_out)
        else $error("polarity flag not latched");
    cover property (reg_rd_in && reg_addr_in == 5'h1A && polarity_copy_out);
    cover property (tone_mode_out);
    cover property (pattern_gap_cycles_out == GAP_LONG_CYC);
endmodule
`default_nettype wire

// ===== testbench/tb_ptp_ctrl_regs.sv
// self-checking bench for the phy test-pattern control registers
`timescale 1ns/1ps
`default_nettype none
module tb_ptp_ctrl_regs;
    import ptp_regs_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic spd = 1'b0, fdx = 1'b0, pol = 1'b0, st = 1'b0, act = 1'b0, ne = 1'b0;
    logic wr, rd, rv, hb, jab, pc, nst, lpo, tone, eso;
    logic [4:0] addr;
    logic [15:0] wd, rdat;
    logic [1:0] pch;
    logic [9:0] gap;
    int n_fail = 0;
    int checks_done = 0;
    always #10 clk = ~clk;
    ptp_ctrl_regs dut (.sys_clk_in(clk), .reset_n_in(rst_n), .reg_addr_in(addr), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_wdata_in(wd), .reg_rdata_out(rdat), .reg_rvalid_out(rv),
        .speed_100_in(spd), .full_duplex_in(fdx), .polarity_inv_in(pol), .selftest_start_in(st),
        .selftest_active_in(act), .nibble_err_in(ne), .heartbeat_en_out(hb), .jabber_en_out(jab),
        .polarity_copy_out(pc), .selftest_nonstop_tx_out(nst), .line_pattern_on_out(lpo),
        .pattern_choice_out(pch), .tone_mode_out(tone), .pattern_gap_cycles_out(gap),
        .energy_sense_on_out(eso));
    ptp_mgmt_model mgmt (.clk_in(clk), .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wd),
        .rdata_in(rdat), .rvalid_in(rv));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] e, input string nm);
        logic [15:0] d;
        mgmt.rd(a, d);
        chk(nm, d, e);
    endtask
    task automatic nx(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic t_reset();
        chk("gap", 16'(gap), 16'(GAP_SHORT_CYC));
        rd_chk(5'h1B, 16'h0000, "ext_rst");
        rd_chk(5'h1D, 16'h0000, "energy_rst");
        rd_chk(5'h1C, 16'h0000, "unmapped");
    endtask
    task automatic t_hb();
        mgmt.wr(5'h1A, 16'hFFFC);
        nx(1);
        chk("hb", 16'(hb), 16'h0001);
        chk("jab", 16'(jab), 16'h0001);
        rd_chk(5'h1A, 16'h0000, "tenmeg_ro");
        spd = 1'b1;
        nx(1);
        chk("hb100", 16'(hb), 16'h0000);
        chk("jab100", 16'(jab), 16'h0000);
        spd = 1'b0;
        fdx = 1'b1;
        nx(1);
        chk("hbfd", 16'(hb), 16'h0000);
        fdx = 1'b0;
        mgmt.wr(5'h1A, 16'h0003);
        nx(1);
        chk("hb_inh", 16'(hb), 16'h0000);
        chk("jab_off", 16'(jab), 16'h0000);
        rd_chk(5'h1A, 16'h0003, "tenmeg");
    endtask
    task automatic t_pat();
        mgmt.wr(5'h1A, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            mgmt.wr(5'h1B, 16'h0034 | 16'(i));
            nx(1);
            chk("choice", 16'(pch), 16'(i));
            chk("tone", 16'(tone), 16'(i == 3));
            chk("lpo", 16'(lpo), 16'h0001);
            chk("nst", 16'(nst), 16'h0001);
            chk("gap15", 16'(gap), 16'(GAP_LONG_CYC));
        end
        mgmt.wr(5'h1B, 16'hFF03);
        nx(1);
        chk("tone_off", 16'(tone), 16'h0000);
        chk("gap10", 16'(gap), 16'(GAP_SHORT_CYC));
        mgmt.wr(5'h1B, 16'hFF00);
        rd_chk(5'h1B, 16'h0000, "tally_ro");
    endtask
    task automatic t_tally();
        st = 1'b1;
        act = 1'b1;
        nx(1);
        st = 1'b0;
        ne = 1'b1;
        nx(5);
        act = 1'b0;
        nx(3);
        ne = 1'b0;
        rd_chk(5'h1B, 16'h0500, "tally5");
        act = 1'b1;
        ne = 1'b1;
        nx(300);
        ne = 1'b0;
        rd_chk(5'h1B, 16'hFF00, "tally_sat");
        st = 1'b1;
        nx(1);
        st = 1'b0;
        act = 1'b0;
        rd_chk(5'h1B, 16'h0000, "tally_clr");
    endtask
    task automatic t_pol();
        pol = 1'b1;
        nx(1);
        pol = 1'b0;
        rd_chk(5'h1B, 16'h0000, "ext_rd");
        chk("pol_kept", 16'(pc), 16'h0001);
        rd_chk(5'h1A, 16'h0011, "pol_rd");
        chk("pol_clr", 16'(pc), 16'h0000);
        rd_chk(5'h1A, 16'h0001, "pol_rd2");
    endtask
    task automatic t_energy();
        // crossover switch lives outside this bank
        mgmt.wr(5'h1D, 16'hFFFF);
        chk("eso", 16'(eso), 16'h0001);
        rd_chk(5'h1D, 16'h8000, "energy");
        mgmt.wr(5'h1D, 16'h7FFF);
        chk("eso_off", 16'(eso), 16'h0000);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        nx(16);
        rst_n = 1'b1;
        nx(1);
        t_reset();
        t_hb();
        t_pat();
        t_tally();
        t_pol();
        t_energy();
        summarize();
    end
    // whole run is under 1000 cycles; this leaves ample margin
    initial begin
        #400000;
        n_fail++;
        summarize();
    end
endmodule
bind ptp_ctrl_regs ptp_ctrl_regs_chk u_chk (.sys_clk_in, .reset_n_in, .reg_addr_in, .reg_wr_in,
    .reg_rd_in, .reg_wdata_in, .reg_rvalid_out, .speed_100_in, .full_duplex_in, .polarity_inv_in,
    .heartbeat_en_out, .jabber_en_out, .polarity_copy_out, .selftest_nonstop_tx_out,
    .line_pattern_on_out, .pattern_choice_out, .tone_mode_out, .pattern_gap_cycles_out,
    .energy_sense_on_out);
`default_nettype wire
